// ==== core/pmeg_defs.vh ====
// register map, field positions, reset values and mode codes of the pwm edge generator
`ifndef PMEG_DEFS_VH
`define PMEG_DEFS_VH

// register byte offsets, one aligned word each
`define PMEG_OFS_CTRL 8'h00
`define PMEG_OFS_PERIOD 8'h04
`define PMEG_OFS_EVENT1 8'h08
`define PMEG_OFS_EVENT2 8'h0c
`define PMEG_OFS_EVENT3 8'h10
`define PMEG_OFS_EVENT4 8'h14
`define PMEG_OFS_CYC_ADJ_A 8'h18
`define PMEG_OFS_CYC_ADJ_B 8'h1c
`define PMEG_OFS_ADAPT 8'h20
`define PMEG_OFS_PHASE 8'h24
`define PMEG_OFS_SAMPLE1 8'h28
`define PMEG_OFS_SAMPLE2 8'h2c
`define PMEG_OFS_BLANK_A_BEG 8'h30
`define PMEG_OFS_BLANK_A_END 8'h34
`define PMEG_OFS_BLANK_B_BEG 8'h38
`define PMEG_OFS_BLANK_B_END 8'h3c
`define PMEG_OFS_STATUS 8'h40

// register file depth, index = offset / 4
`define PMEG_NUM_CFG 16
`define PMEG_IDX_CTRL 4'h0
`define PMEG_IDX_PERIOD 4'h1
`define PMEG_IDX_EVENT1 4'h2
`define PMEG_IDX_EVENT2 4'h3
`define PMEG_IDX_EVENT3 4'h4
`define PMEG_IDX_EVENT4 4'h5
`define PMEG_IDX_CYC_ADJ_A 4'h6
`define PMEG_IDX_CYC_ADJ_B 4'h7
`define PMEG_IDX_ADAPT 4'h8
`define PMEG_IDX_PHASE 4'h9
`define PMEG_IDX_SAMPLE1 4'ha
`define PMEG_IDX_SAMPLE2 4'hb
`define PMEG_IDX_BLANK_A_BEG 4'hc
`define PMEG_IDX_BLANK_A_END 4'hd
`define PMEG_IDX_BLANK_B_BEG 4'he
`define PMEG_IDX_BLANK_B_END 4'hf

// control register fields
`define PMEG_CTRL_MODE_LSB 0
`define PMEG_CTRL_MODE_MSB 1
`define PMEG_CTRL_PHASE_SEL 2
`define PMEG_CTRL_ENABLE 3

// reset values
`define PMEG_RST_CTRL 16'h0000
`define PMEG_RST_PERIOD 16'h00ff
`define PMEG_RST_OTHER 16'h0000

// operating modes
`define PMEG_MODE_MULTI 2'h0
`define PMEG_MODE_RESONANT 2'h1
`define PMEG_MODE_TRIANGLE 2'h2
`define PMEG_MODE_LEADING 2'h3

// axi responses
`define PMEG_RESP_OKAY 2'h0
`define PMEG_RESP_SLVERR 2'h2

`endif

// ==== core/pmeg_edge_gen.v ====
// pwm edge generator for multi, resonant, triangular and leading-edge modes
//
// Overview of operation
// - period counter counts zero to limit, wraps
// - signal changes when counter equals its target
// - multi mode ignores events two and four
// - multi: B may cross boundary, A never
// - multi: cycle adjust B moves B fall
// - resonant: A rises event1, falls minus mean dead
// - resonant: B rises A fall plus e3-e2
// - resonant: B falls filter period minus (prd-e4)
// - resonant: filter period supplies the counter limit
// - resonant: mean dead time from e3-e2 and prd-e4
// - resonant: adaptive triggers at duty, half duty
// - phase trigger from register or filter duty
// - sample and blanking counts straight from registers
// - triangular: only B, no adaptive triggers
// - triangular: B rises half period minus half duty
// - triangular: B falls half period plus half duty
// - leading: A falls event1, rises event1 minus duty
// - leading: adaptive triggers before event1
// - leading: B rises event4, falls before A rise
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pmeg_defs.vh"

module pmeg_edge_gen (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address and data
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // compensation filter results
    input wire [15:0] filter_duty,
    input wire [15:0] filter_period,
    // gate drive outputs
    output reg pwm_output_a,
    output reg pwm_output_b,
    // trigger pulses and blanking windows
    output reg adapt_trig_a,
    output reg adapt_trig_b,
    output reg phase_trig,
    output reg sample_trig1,
    output reg sample_trig2,
    output reg blank_a,
    output reg blank_b
);

    // configuration words, 16 bits significant
    reg [15:0] cfg_q [0:`PMEG_NUM_CFG-1];

    // axi state
    reg [7:0] aw_addr_q;
    reg aw_have_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg w_have_q;
    wire wr_fire;
    wire wr_hit;
    wire [3:0] wr_idx;
    integer i;

    // period state latched at each period start
    reg [15:0] cnt_q;
    reg [1:0] mode_q;
    reg [15:0] duty_q;
    reg [15:0] fper_q;
    reg running_q;

    // shorthand views of the configuration
    wire [1:0] cfg_mode;
    wire phase_sel;
    wire enable;
    wire [15:0] period_limit;
    wire [17:0] e1;
    wire [17:0] e2;
    wire [17:0] e3;
    wire [17:0] e4;
    wire [17:0] caa;
    wire [17:0] cab;
    wire [17:0] adp;
    wire [17:0] dty;
    wire [17:0] dty_half;
    wire [15:0] limit;
    wire [17:0] len;
    wire wrap;

    assign cfg_mode = cfg_q[`PMEG_IDX_CTRL][`PMEG_CTRL_MODE_MSB:`PMEG_CTRL_MODE_LSB];
    assign phase_sel = cfg_q[`PMEG_IDX_CTRL][`PMEG_CTRL_PHASE_SEL];
    assign enable = cfg_q[`PMEG_IDX_CTRL][`PMEG_CTRL_ENABLE];
    assign period_limit = cfg_q[`PMEG_IDX_PERIOD];
    assign e1 = {2'b00, cfg_q[`PMEG_IDX_EVENT1]};
    assign e2 = {2'b00, cfg_q[`PMEG_IDX_EVENT2]};
    assign e3 = {2'b00, cfg_q[`PMEG_IDX_EVENT3]};
    assign e4 = {2'b00, cfg_q[`PMEG_IDX_EVENT4]};
    // cycle adjusts and adaptive offset are two's complement
    assign caa = {{2{cfg_q[`PMEG_IDX_CYC_ADJ_A][15]}}, cfg_q[`PMEG_IDX_CYC_ADJ_A]};
    assign cab = {{2{cfg_q[`PMEG_IDX_CYC_ADJ_B][15]}}, cfg_q[`PMEG_IDX_CYC_ADJ_B]};
    assign adp = {{2{cfg_q[`PMEG_IDX_ADAPT][15]}}, cfg_q[`PMEG_IDX_ADAPT]};
    assign dty = {2'b00, duty_q};
    assign dty_half = {3'b000, duty_q[15:1]};

    // resonant mode runs on the filter period, the others on the period register
    assign limit = (mode_q == `PMEG_MODE_RESONANT) ? fper_q : period_limit;
    assign len = {2'b00, limit} + 18'h00001;
    assign wrap = (cnt_q >= limit);

    // fold a target into one period; one fold only, so targets beyond a period alias
    function [15:0] pmeg_fold;
        input [17:0] x;
        input [17:0] n;
        reg [17:0] y;
        begin
            y = x;
            if (y[17])
                y = y + n;
            else if (y >= n)
                y = y - n;
            pmeg_fold = y[15:0];
        end
    endfunction

    // write channel: address and data taken in either order
    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_idx = aw_addr_q[5:2];
    assign wr_hit = (aw_addr_q[7:6] == 2'b00) && (aw_addr_q[1:0] == 2'b00);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `PMEG_RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end
        else
        begin
            // ready rises only once reset is gone
            if (!aw_have_q && !s_axi_bvalid && !s_axi_awready)
                s_axi_awready <= 1'b1;
            if (!w_have_q && !s_axi_bvalid && !s_axi_wready)
                s_axi_wready <= 1'b1;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_addr_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                w_have_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `PMEG_RESP_OKAY : `PMEG_RESP_SLVERR;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // register file; only the two low byte lanes carry bits
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            for (i = 0; i < `PMEG_NUM_CFG; i = i + 1)
                cfg_q[i] <= `PMEG_RST_OTHER;
            cfg_q[`PMEG_IDX_CTRL] <= `PMEG_RST_CTRL;
            cfg_q[`PMEG_IDX_PERIOD] <= `PMEG_RST_PERIOD;
        end
        else if (wr_fire && wr_hit)
        begin
            if (w_strb_q[0])
                cfg_q[wr_idx][7:0] <= w_data_q[7:0];
            if (w_strb_q[1])
                cfg_q[wr_idx][15:8] <= w_data_q[15:8];
        end
    end

    // read channel, data one cycle after the address is taken
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PMEG_RESP_OKAY;
        end
        else
        begin
            if (!s_axi_rvalid && !s_axi_arready)
                s_axi_arready <= 1'b1;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `PMEG_RESP_OKAY;
                if (s_axi_araddr[1:0] != 2'b00)
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `PMEG_RESP_SLVERR;
                end
                else if (s_axi_araddr[7:6] == 2'b00)
                    s_axi_rdata <= {16'h0000, cfg_q[s_axi_araddr[5:2]]};
                else if (s_axi_araddr == `PMEG_OFS_STATUS)
                    s_axi_rdata <= {11'h000, running_q, pwm_output_b, pwm_output_a,
                                    mode_q, cnt_q};
                else
                begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `PMEG_RESP_SLVERR;
                end
            end
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // period counter; mode and duty are frozen per period so edges stay coherent
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_q <= 16'h0000;
            mode_q <= `PMEG_MODE_MULTI;
            duty_q <= 16'h0000;
            fper_q <= 16'h0000;
            running_q <= 1'b0;
        end
        else if (!enable)
        begin
            cnt_q <= 16'h0000;
            mode_q <= cfg_mode;
            duty_q <= filter_duty;
            fper_q <= filter_period;
            running_q <= 1'b0;
        end
        else
        begin
            running_q <= 1'b1;
            if (wrap)
            begin
                cnt_q <= 16'h0000;
                mode_q <= cfg_mode;
                duty_q <= filter_duty;
                fper_q <= filter_period;
            end
            else
                cnt_q <= cnt_q + 16'h0001;
        end
    end

    // edge targets of the active mode
    reg [17:0] a_rise_r;
    reg [17:0] a_fall_r;
    reg [17:0] b_rise_r;
    reg [17:0] b_fall_r;
    reg [17:0] ta_r;
    reg [17:0] tb_r;
    reg [17:0] dt_sum;
    reg [17:0] dt_avg;
    reg a_used;
    reg adapt_used;
    reg a_clamp;

    always @*
    begin
        dt_sum = (e3 - e2) + ({2'b00, period_limit} - e4);
        dt_avg = {dt_sum[17], dt_sum[17:1]};
        a_rise_r = e1;
        a_fall_r = e1 + dty + caa;
        b_rise_r = e3;
        b_fall_r = e3 + dty + cab;
        ta_r = e1 + dty + adp;
        tb_r = e1 + dty_half + adp;
        a_used = 1'b1;
        adapt_used = 1'b1;
        a_clamp = 1'b0;
        case (mode_q)
            `PMEG_MODE_MULTI:
            begin
                // events two and four take no part here
                b_rise_r = e3;
                b_fall_r = e3 + dty + cab;
                a_clamp = 1'b1;
            end
            `PMEG_MODE_RESONANT:
            begin
                a_rise_r = e1;
                a_fall_r = e1 + dty - dt_avg;
                b_rise_r = e1 + dty - dt_avg + (e3 - e2);
                b_fall_r = {2'b00, fper_q} - ({2'b00, period_limit} - e4);
                ta_r = e1 + dty + adp;
                tb_r = e1 + dty_half + adp;
            end
            `PMEG_MODE_TRIANGLE:
            begin
                a_used = 1'b0;
                adapt_used = 1'b0;
                b_rise_r = {3'b000, period_limit[15:1]} - dty_half + caa;
                b_fall_r = {3'b000, period_limit[15:1]} + dty_half + cab;
            end
            `PMEG_MODE_LEADING:
            begin
                a_fall_r = e1;
                a_rise_r = e1 - dty + caa;
                ta_r = e1 - dty + adp;
                tb_r = e1 - dty_half + adp;
                b_rise_r = e4;
                b_fall_r = e1 - dty + caa - (e2 - e3);
            end
            default:
            begin
                a_used = 1'b0;
                adapt_used = 1'b0;
            end
        endcase
    end

    // folded compare values
    wire [15:0] a_rise_t;
    wire [15:0] a_fall_t;
    wire [15:0] b_rise_t;
    wire [15:0] b_fall_t;
    wire [15:0] ta_t;
    wire [15:0] tb_t;
    wire [15:0] phase_t;

    assign a_rise_t = pmeg_fold(a_rise_r, len);
    // in multi mode a past the period end is cut at the boundary instead of wrapping
    assign a_fall_t = (a_clamp && (a_fall_r >= len)) ? limit : pmeg_fold(a_fall_r, len);
    // b folds freely, so its pulse may straddle the boundary at full width
    assign b_rise_t = pmeg_fold(b_rise_r, len);
    assign b_fall_t = pmeg_fold(b_fall_r, len);
    assign ta_t = pmeg_fold(ta_r, len);
    assign tb_t = pmeg_fold(tb_r, len);
    assign phase_t = phase_sel ? duty_q : cfg_q[`PMEG_IDX_PHASE];

    // outputs change on counter match; fall wins when both targets coincide
    always @(posedge aclk)
    begin
        if (!aresetn || !enable)
        begin
            pwm_output_a <= 1'b0;
            pwm_output_b <= 1'b0;
            adapt_trig_a <= 1'b0;
            adapt_trig_b <= 1'b0;
            phase_trig <= 1'b0;
            sample_trig1 <= 1'b0;
            sample_trig2 <= 1'b0;
            blank_a <= 1'b0;
            blank_b <= 1'b0;
        end
        else
        begin
            if (!a_used)
                pwm_output_a <= 1'b0;
            else if (cnt_q == a_fall_t)
                pwm_output_a <= 1'b0;
            else if (cnt_q == a_rise_t)
                pwm_output_a <= 1'b1;
            else if (a_clamp && wrap)
                pwm_output_a <= 1'b0;
            if (cnt_q == b_fall_t)
                pwm_output_b <= 1'b0;
            else if (cnt_q == b_rise_t)
                pwm_output_b <= 1'b1;
            adapt_trig_a <= adapt_used && (cnt_q == ta_t);
            adapt_trig_b <= adapt_used && (cnt_q == tb_t);
            phase_trig <= (cnt_q == phase_t);
            sample_trig1 <= (cnt_q == cfg_q[`PMEG_IDX_SAMPLE1]);
            sample_trig2 <= (cnt_q == cfg_q[`PMEG_IDX_SAMPLE2]);
            // blanking windows, end takes priority over begin
            if (cnt_q == cfg_q[`PMEG_IDX_BLANK_A_END])
                blank_a <= 1'b0;
            else if (cnt_q == cfg_q[`PMEG_IDX_BLANK_A_BEG])
                blank_a <= 1'b1;
            if (cnt_q == cfg_q[`PMEG_IDX_BLANK_B_END])
                blank_b <= 1'b0;
            else if (cnt_q == cfg_q[`PMEG_IDX_BLANK_B_BEG])
                blank_b <= 1'b1;
        end
    end

endmodule

// ==== verification/pmeg_edge_gen_assertions.sv ====
// port-level concurrent checks for the pwm edge generator
`timescale 1ns/1ps
module pmeg_edge_gen_chk (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // register bus handshakes
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // gate and trigger outputs
    input wire pwm_output_a,
    input wire pwm_output_b,
    input wire adapt_trig_a,
    input wire phase_trig,
    input wire sample_trig1
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // nothing may be left over from before reset
    AST_RST_QUIET: assert property ($rose(aresetn) |-> !pwm_output_a && !pwm_output_b
        && !s_axi_bvalid && !s_axi_rvalid) else $error("output active after reset");
    // one write at a time: address channel closes after taking
    AST_AW_DROP: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("awready stayed high after a write address");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped early");
    AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    // a running counter with a nonzero limit never holds a value two cycles, so a target hit is one cycle
    AST_TRIG_PULSE: assert property (adapt_trig_a |=> !adapt_trig_a)
        else $error("adaptive trigger longer than one cycle");
    AST_PHASE_PULSE: assert property (phase_trig |=> !phase_trig)
        else $error("phase trigger longer than one cycle");
    AST_SAMPLE_PULSE: assert property (sample_trig1 |=> !sample_trig1)
        else $error("sample trigger longer than one cycle");
endmodule

// ==== verification/pmeg_gate_model.sv ====
// gate driver model: timestamps pwm edges and reports pulse geometry
`timescale 1ns/1ps
module pmeg_gate_model (
    // clock and result clear
    input wire aclk,
    input wire clr,
    // gate inputs
    input wire pwm_output_a,
    input wire pwm_output_b,
    // cycle count and measured geometry
    output int t,
    output int a_rise,
    output int a_w,
    output int b_w,
    output int ab_ofs,
    output int a_per
);
    int b_rise;
    logic a_q = 1'b0;
    logic b_q = 1'b0;

    // rise times kept across a clear, so pulses that straddle it still measure
    always @(posedge aclk)
    begin
        t <= t + 1;
        a_q <= pwm_output_a;
        b_q <= pwm_output_b;
        if (clr)
        begin
            a_w <= 0;
            b_w <= 0;
            ab_ofs <= 0;
            a_per <= 0;
        end
        if (pwm_output_a && !a_q)
        begin
            a_rise <= t;
            a_per <= t - a_rise;
        end
        if (!pwm_output_a && a_q)
            a_w <= t - a_rise;
        if (pwm_output_b && !b_q)
        begin
            b_rise <= t;
            ab_ofs <= t - a_rise;
        end
        if (!pwm_output_b && b_q)
            b_w <= t - b_rise;
    end
endmodule

// ==== verification/pmeg_edge_gen_tb_top.sv ====
// self-checking bench for the pwm edge generator
`timescale 1ns/1ps
`include "pmeg_defs.vh"
module pmeg_edge_gen_tb_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic clr = 1'b0;
    logic [15:0] duty = 16'h0;
    logic [15:0] fper = 16'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic pa, pb, tga, tgb, ph, s1, s2, bla, blb;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [7:0] ev;
    logic [7:0] ev_q = 8'h00;
    int t, a_rise, a_w, b_w, ab_ofs, a_per;
    int ev_ofs[8];
    int ev_n[8];
    int fail_count = 0;
    int n_checks = 0;
    // mode e1 e2 e3 e4 adja adjb duty fper | a_w b_w ofs per adapt_a adapt_b
    int rows[6][15] = '{'{0, 2, 30, 10, 5, 1, 3, 12, 0, 13, 15, 8, 41, 14, 8},
        '{0, 2, 0, 30, 0, 0, 0, 20, 0, 20, 20, 28, 41, 22, 12},
        '{0, 30, 0, 5, 0, 0, 0, 20, 0, 10, 20, 16, 41, 22, 12},
        '{1, 2, 4, 8, 36, 0, 0, 24, 48, 20, 18, 24, 49, 26, 14},
        '{2, 2, 4, 8, 36, 1, 2, 20, 0, 0, 21, -1, 0, -1, -1},
        '{3, 30, 8, 4, 2, 1, 0, 10, 0, 9, 15, 22, 41, 1, 6}};
    int fx[6] = '{7, 3, 33, 4, 9, 15};

    always #5 aclk = ~aclk;

    pmeg_edge_gen u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .filter_duty(duty), .filter_period(fper),
        .pwm_output_a(pa), .pwm_output_b(pb), .adapt_trig_a(tga), .adapt_trig_b(tgb),
        .phase_trig(ph), .sample_trig1(s1), .sample_trig2(s2), .blank_a(bla),
        .blank_b(blb));

    pmeg_gate_model u_gate (.aclk(aclk), .clr(clr), .pwm_output_a(pa), .pwm_output_b(pb),
        .t(t), .a_rise(a_rise), .a_w(a_w), .b_w(b_w), .ab_ofs(ab_ofs), .a_per(a_per));

    // trigger and blanking edges timed from the latest a rise
    assign ev = {blb, !bla, bla, s2, s1, ph, tgb, tga};
    always @(posedge aclk)
    begin
        ev_q <= ev;
        for (int i = 0; i < 8; i++)
        begin
            if (ev[i] && !ev_q[i])
            begin
                ev_ofs[i] <= t - a_rise;
                ev_n[i] <= ev_n[i] + 1;
            end
            if (clr)
                ev_n[i] <= 0;
        end
    end

    task automatic chk(input string n, input logic [34:0] e, input logic [34:0] g);
        begin
            n_checks++;
            if (g !== e)
            begin
                fail_count++;
                $display("ERROR %s expected %0h seen %0h", n, e, g);
            end
        end
    endtask

    // bus write; each channel held until its own ready
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        begin
            k = 0;
            @(posedge aclk);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do
            begin
                @(posedge aclk);
                k++;
                if (awready)
                    awvalid <= 1'b0;
                if (wready)
                    wvalid <= 1'b0;
            end
            while (!bvalid && k < 50);
            bready <= 1'b0;
            chk("bresp", {1'b1, er}, {bvalid, bresp});
        end
    endtask

    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int k;
        begin
            k = 0;
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do
            begin
                @(posedge aclk);
                k++;
                if (arready)
                    arvalid <= 1'b0;
            end
            while (!rvalid && k < 50);
            rready <= 1'b0;
            chk("rdata", {1'b1, er, ed}, {rvalid, rresp, rdata});
        end
    endtask

    // settle several periods, clear results, measure several more
    task automatic measure;
        begin
            repeat (200) @(posedge aclk);
            clr <= 1'b1;
            @(posedge aclk);
            clr <= 1'b0;
            repeat (200) @(posedge aclk);
        end
    endtask

    task automatic wrap_up;
        begin
            $display("checks %0d errors %0d", n_checks, fail_count);
            if (fail_count == 0 && n_checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    // hang guard, well beyond the expected run
    initial
    begin
        #200000;
        fail_count++;
        wrap_up;
    end

    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chk("reset_outputs", 0, {pa, pb, tga, ph});
        axr(`PMEG_OFS_CTRL, 0, `PMEG_RESP_OKAY);
        axr(`PMEG_OFS_PERIOD, 32'h00ff, `PMEG_RESP_OKAY);
        axw(`PMEG_OFS_STATUS, 32'h1, `PMEG_RESP_SLVERR);
        axw(8'h02, 32'h5, `PMEG_RESP_SLVERR);
        axr(8'h44, 0, `PMEG_RESP_SLVERR);
        // upper half of a word is not stored
        axw(`PMEG_OFS_PERIOD, 32'hdead0028, `PMEG_RESP_OKAY);
        axr(`PMEG_OFS_PERIOD, 32'h0028, `PMEG_RESP_OKAY);
        axw(`PMEG_OFS_ADAPT, 32'h2, `PMEG_RESP_OKAY);
        // one row per mode and boundary case, disabled while reprogrammed
        for (int r = 0; r < 6; r++)
        begin
            axw(`PMEG_OFS_CTRL, 0, `PMEG_RESP_OKAY);
            for (int i = 0; i < 6; i++)
                axw(`PMEG_OFS_EVENT1 + 8'(4 * i), rows[r][i + 1], `PMEG_RESP_OKAY);
            duty <= 16'(rows[r][7]);
            fper <= 16'(rows[r][8]);
            axw(`PMEG_OFS_CTRL, rows[r][0] | 8, `PMEG_RESP_OKAY);
            measure;
            chk("a_width", rows[r][9], a_w);
            chk("b_width", rows[r][10], b_w);
            if (rows[r][11] >= 0)
                chk("b_offset", rows[r][11], ab_ofs);
            chk("a_period", rows[r][12], a_per);
            if (rows[r][13] < 0)
                chk("adapt_count", 0, ev_n[0] + ev_n[1]);
            else
            begin
                chk("adapt_a", rows[r][13], ev_ofs[0]);
                chk("adapt_b", rows[r][14], ev_ofs[1]);
            end
        end
        // fixed events, with both phase sources
        axw(`PMEG_OFS_CTRL, 0, `PMEG_RESP_OKAY);
        axw(`PMEG_OFS_EVENT1, 0, `PMEG_RESP_OKAY);
        for (int i = 0; i < 6; i++)
            axw(`PMEG_OFS_PHASE + 8'(4 * i), fx[i], `PMEG_RESP_OKAY);
        duty <= 16'hc;
        for (int s = 0; s < 2; s++)
        begin
            axw(`PMEG_OFS_CTRL, 8 | 4 * s, `PMEG_RESP_OKAY);
            measure;
            chk("phase_trig", s ? 12 : 7, ev_ofs[2]);
            for (int i = 1; i < 6; i++)
                chk("fixed_event", fx[i], ev_ofs[i + 2]);
        end
        // reset while running drops the gates and restores the registers
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chk("midrun_reset_outputs", 0, {pa, pb, tga, ph});
        axr(`PMEG_OFS_PERIOD, 32'h00ff, `PMEG_RESP_OKAY);
        axr(`PMEG_OFS_CTRL, 0, `PMEG_RESP_OKAY);
        // disabled block keeps the gates off
        axw(`PMEG_OFS_CTRL, 0, `PMEG_RESP_OKAY);
        measure;
        chk("idle_outputs", 0, {pa, pb, a_per});
        // status shows the latched mode while disabled, counter parked at zero
        axw(`PMEG_OFS_CTRL, `PMEG_MODE_LEADING, `PMEG_RESP_OKAY);
        axr(`PMEG_OFS_STATUS, 32'h00030000, `PMEG_RESP_OKAY);
        wrap_up;
    end
endmodule

bind pmeg_edge_gen pmeg_edge_gen_chk u_chk (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .pwm_output_a(pwm_output_a),
    .pwm_output_b(pwm_output_b),
    .adapt_trig_a(adapt_trig_a),
    .phase_trig(phase_trig),
    .sample_trig1(sample_trig1)
);
